// *** rtl/dbs_defines.svh ***
// Offsets, field positions and reset values of the descriptor base and status registers
`ifndef DBS_DEFINES_SVH
`define DBS_DEFINES_SVH

`define DBS_RX_BASE_OFF   8'h18
`define DBS_TX_BASE_OFF   8'h20
`define DBS_STATUS_OFF    8'h28
`define DBS_IMASK_OFF     8'h38
`define DBS_GP_MASK_OFF   8'h40
`define DBS_LINK_OFF      8'h60

`define DBS_LC_BIT        27
`define DBS_GPI_BIT       26
`define DBS_AIS_BIT       15
`define DBS_LINK_BIT      1
`define DBS_GP_LO_BIT     28
`define DBS_GP_HI_BIT     30

`define DBS_BASE_RST      32'h0000_0000
`define DBS_MASK_RST      32'h0000_0000
`define DBS_RDATA_RST     32'h0000_0000

`endif

// *** rtl/dbs_pkg.sv ***
// Types shared by the descriptor base and status register bank
package dbs_pkg;

	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} dbs_bus_req_t;

	typedef struct packed {
		logic [31:0] rx_base;
		logic [31:0] tx_base;
	} dbs_fetch_t;

endpackage

// *** rtl/dbs_regs.sv ***
// Descriptor list base registers and host status flags

`include "dbs_defines.svh"

module dbs_regs (
	input  wire logic                 core_clk,
	input  wire logic                 rst_b,
	input  wire dbs_pkg::dbs_bus_req_t bus_req,
	output logic [31:0]               bus_rdata,
	input  wire logic                 link_pass_pin,
	input  wire logic [2:0]           gp_src_event,
	input  wire logic                 abn_other,
	output dbs_pkg::dbs_fetch_t       fetch_base,
	output logic                      abnormal_summary
);

	////////////////////////////////////////////////////////////////////////////
	// State

	logic [31:2] rx_base_q;
	logic [31:2] rx_base_d;
	logic [31:2] tx_base_q;
	logic [31:2] tx_base_d;
	logic [31:0] imask_q;
	logic [31:0] imask_d;
	logic [2:0]  gp_mask_q;
	logic [2:0]  gp_mask_d;
	logic [2:0]  gp_src_q;
	logic [2:0]  gp_src_d;
	logic        lc_q;
	logic        lc_d;
	logic        link_s1_q;
	logic        link_s2_q;
	logic        link_s3_q;
	logic [31:0] rdata_q;
	logic [31:0] rdata_d;

	logic        wr_rx;
	logic        wr_tx;
	logic        wr_status;
	logic        wr_imask;
	logic        wr_gp_mask;
	logic        lc_set;
	logic        gp_port_interrupt_flag;
	logic [31:0] status_view;

	// Reset value kept as a full word so the stored field is cut on purpose
	localparam logic [31:0] BASE_RST = `DBS_BASE_RST;

	////////////////////////////////////////////////////////////////////////////
	// Decode

	assign wr_rx      = bus_req.wr && (bus_req.addr == `DBS_RX_BASE_OFF);
	assign wr_tx      = bus_req.wr && (bus_req.addr == `DBS_TX_BASE_OFF);
	assign wr_status  = bus_req.wr && (bus_req.addr == `DBS_STATUS_OFF);
	assign wr_imask   = bus_req.wr && (bus_req.addr == `DBS_IMASK_OFF);
	assign wr_gp_mask = bus_req.wr && (bus_req.addr == `DBS_GP_MASK_OFF);

	////////////////////////////////////////////////////////////////////////////
	// Flags and summary

	// Only synchronised stages feed the edge detector
	assign lc_set = link_s2_q != link_s3_q;

	assign gp_port_interrupt_flag = |(gp_src_q & ~gp_mask_q);

	assign abnormal_summary = (lc_q && !imask_q[`DBS_LC_BIT])
		|| (gp_port_interrupt_flag && !imask_q[`DBS_GPI_BIT])
		|| abn_other;

	always_comb begin
		status_view = 32'h0000_0000;
		status_view[`DBS_LC_BIT]  = lc_q;
		status_view[`DBS_GPI_BIT] = gp_port_interrupt_flag;
		status_view[`DBS_AIS_BIT] = abnormal_summary;
	end

	// Bases are used as written; software must hold the process stopped
	assign fetch_base.rx_base = {rx_base_q, 2'b00};
	assign fetch_base.tx_base = {tx_base_q, 2'b00};
	assign bus_rdata = rdata_q;

	////////////////////////////////////////////////////////////////////////////
	// Next state

	always_comb begin
		rx_base_d = rx_base_q;
		tx_base_d = tx_base_q;
		imask_d   = imask_q;
		gp_mask_d = gp_mask_q;
		gp_src_d  = gp_src_q;
		lc_d      = lc_q;
		rdata_d   = 32'h0000_0000;
		if (wr_rx) begin
			rx_base_d = bus_req.wdata[31:2];
		end
		if (wr_tx) begin
			tx_base_d = bus_req.wdata[31:2];
		end
		if (wr_imask) begin
			imask_d = bus_req.wdata;
		end
		if (wr_gp_mask) begin
			gp_mask_d = bus_req.wdata[`DBS_GP_HI_BIT:`DBS_GP_LO_BIT];
		end
		// Clear first so that a same-cycle event wins
		if (wr_status && bus_req.wdata[`DBS_LC_BIT]) begin
			lc_d = 1'b0;
		end
		if (wr_status && bus_req.wdata[`DBS_GPI_BIT]) begin
			gp_src_d = 3'h0;
		end
		if (lc_set) begin
			lc_d = 1'b1;
		end
		gp_src_d = gp_src_d | gp_src_event;
		// Reads only select data; nothing is cleared here
		if (bus_req.rd) begin
			unique case (bus_req.addr)
				`DBS_RX_BASE_OFF: rdata_d = {rx_base_q, 2'b00};
				`DBS_TX_BASE_OFF: rdata_d = {tx_base_q, 2'b00};
				`DBS_STATUS_OFF:  rdata_d = status_view;
				`DBS_IMASK_OFF:   rdata_d = imask_q;
				`DBS_GP_MASK_OFF: rdata_d = {1'b0, gp_mask_q, 28'h0000000};
				`DBS_LINK_OFF:    rdata_d = {30'h00000000, link_s2_q, 1'b0};
				default:          rdata_d = 32'h0000_0000;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Registers

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_base_q <= BASE_RST[31:2];
			tx_base_q <= BASE_RST[31:2];
			imask_q   <= `DBS_MASK_RST;
			gp_mask_q <= 3'h0;
			gp_src_q  <= 3'h0;
			lc_q      <= 1'b0;
			link_s1_q <= 1'b0;
			link_s2_q <= 1'b0;
			link_s3_q <= 1'b0;
			rdata_q   <= `DBS_RDATA_RST;
		end else begin
			rx_base_q <= rx_base_d;
			tx_base_q <= tx_base_d;
			imask_q   <= imask_d;
			gp_mask_q <= gp_mask_d;
			gp_src_q  <= gp_src_d;
			lc_q      <= lc_d;
			link_s1_q <= link_pass_pin;
			link_s2_q <= link_s1_q;
			link_s3_q <= link_s2_q;
			rdata_q   <= rdata_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	a_rx_base_load: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_rx |=> fetch_base.rx_base[31:2] == $past(bus_req.wdata[31:2]))
		else $error("receive base not loaded");

	a_tx_base_load: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_tx |=> fetch_base.tx_base[31:2] == $past(bus_req.wdata[31:2]))
		else $error("transmit base not loaded");

	a_fetch_align: assert property (@(posedge core_clk) disable iff (!rst_b)
		fetch_base.rx_base[1:0] == 2'h0 && fetch_base.tx_base[1:0] == 2'h0)
		else $error("fetch address not aligned");

	a_read_keeps: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd && lc_q |=> lc_q)
		else $error("read cleared link changed");

	a_w1c_clear: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_status && bus_req.wdata[`DBS_LC_BIT] && !lc_set |=> !lc_q)
		else $error("write one did not clear");

	a_w0_keep: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_status && !bus_req.wdata[`DBS_GPI_BIT] && gp_src_q[0] |=> gp_src_q[0])
		else $error("write zero cleared a flag");

	a_lc_edge: assert property (@(posedge core_clk) disable iff (!rst_b)
		$changed(link_s2_q) && !(wr_status && bus_req.wdata[`DBS_LC_BIT]) |=> lc_q)
		else $error("link change not flagged");

	a_link_view: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd && bus_req.addr == `DBS_LINK_OFF |=> bus_rdata[`DBS_LINK_BIT] == $past(link_s2_q))
		else $error("link status readback wrong");

	a_gpi_or: assert property (@(posedge core_clk) disable iff (!rst_b)
		gp_src_event[2] && !gp_mask_q[2] && !wr_gp_mask |=> gp_port_interrupt_flag)
		else $error("port source not ORed in");

	a_gpi_mask: assert property (@(posedge core_clk) disable iff (!rst_b)
		gp_mask_q == 3'h7 |-> !gp_port_interrupt_flag)
		else $error("masked source reached flag");

	a_ais_mask: assert property (@(posedge core_clk) disable iff (!rst_b)
		!abn_other && (!lc_q || imask_q[`DBS_LC_BIT]) && (!gp_port_interrupt_flag || imask_q[`DBS_GPI_BIT]) |-> !abnormal_summary)
		else $error("masked flags reached summary");

	a_ais_lc: assert property (@(posedge core_clk) disable iff (!rst_b)
		lc_q && !imask_q[`DBS_LC_BIT] |-> abnormal_summary)
		else $error("unmasked link change lost");

	a_rx_base_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		!wr_rx |=> $stable(rx_base_q))
		else $error("receive base changed without a write");

	a_tx_base_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		!wr_tx |=> $stable(tx_base_q))
		else $error("transmit base changed without a write");

	a_rx_read_back: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd && bus_req.addr == `DBS_RX_BASE_OFF |=> bus_rdata == {$past(rx_base_q), 2'b00})
		else $error("receive base readback wrong");

	a_tx_read_back: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd && bus_req.addr == `DBS_TX_BASE_OFF |=> bus_rdata == {$past(tx_base_q), 2'b00})
		else $error("transmit base readback wrong");

	a_rd_idle_zero: assert property (@(posedge core_clk) disable iff (!rst_b)
		!bus_req.rd |=> bus_rdata == 32'h0000_0000)
		else $error("read data outside its cycle");

	a_status_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd && bus_req.addr == `DBS_STATUS_OFF |=> bus_rdata == $past(status_view))
		else $error("status readback wrong");

	a_read_keeps_gp: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd |=> (gp_src_q & $past(gp_src_q)) == $past(gp_src_q))
		else $error("read cleared a port source");

	a_w1c_gp: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_status && bus_req.wdata[`DBS_GPI_BIT] && gp_src_event == 3'h0 |=> gp_src_q == 3'h0)
		else $error("write one did not clear port sources");

	a_w0_keep_lc: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_status && !bus_req.wdata[`DBS_LC_BIT] && lc_q |=> lc_q)
		else $error("write zero cleared link changed");

	a_lc_sticky: assert property (@(posedge core_clk) disable iff (!rst_b)
		lc_q && !(wr_status && bus_req.wdata[`DBS_LC_BIT]) |=> lc_q)
		else $error("link changed dropped by itself");

	a_lc_set_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_status && bus_req.wdata[`DBS_LC_BIT] && lc_set |=> lc_q)
		else $error("clear beat a same cycle link change");

	a_gp_set_wins: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_status && bus_req.wdata[`DBS_GPI_BIT] && gp_src_event[0] |=> gp_src_q[0])
		else $error("clear beat a same cycle port event");

	a_lc_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
		!lc_set && !lc_q |=> !lc_q)
		else $error("link changed set with no change");

	a_gp_quiet: assert property (@(posedge core_clk) disable iff (!rst_b)
		gp_src_event == 3'h0 && gp_src_q == 3'h0 |=> gp_src_q == 3'h0)
		else $error("port source set with no event");

	a_gpi_or_1: assert property (@(posedge core_clk) disable iff (!rst_b)
		gp_src_event[1] && !gp_mask_q[1] && !wr_gp_mask |=> gp_port_interrupt_flag)
		else $error("port source one not ORed in");

	a_gpi_or_0: assert property (@(posedge core_clk) disable iff (!rst_b)
		gp_src_event[0] && !gp_mask_q[0] && !wr_gp_mask |=> gp_port_interrupt_flag)
		else $error("port source zero not ORed in");

	a_link_sync: assert property (@(posedge core_clk) disable iff (!rst_b)
		link_s2_q == $past(link_pass_pin, 2))
		else $error("link status not two stages behind pin");

	a_ais_gp: assert property (@(posedge core_clk) disable iff (!rst_b)
		gp_port_interrupt_flag && !imask_q[`DBS_GPI_BIT] |-> abnormal_summary)
		else $error("unmasked port interrupt lost");

	a_ais_other: assert property (@(posedge core_clk) disable iff (!rst_b)
		abn_other |-> abnormal_summary)
		else $error("other abnormal source lost");

	a_status_ais: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd && bus_req.addr == `DBS_STATUS_OFF |=> bus_rdata[`DBS_AIS_BIT] == $past(abnormal_summary))
		else $error("summary readback wrong");

	a_imask_load: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_imask |=> imask_q == $past(bus_req.wdata))
		else $error("interrupt mask not loaded");

	a_imask_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		!wr_imask |=> $stable(imask_q))
		else $error("interrupt mask changed without a write");

	a_imask_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd && bus_req.addr == `DBS_IMASK_OFF |=> bus_rdata == $past(imask_q))
		else $error("interrupt mask readback wrong");

	a_gp_mask_load: assert property (@(posedge core_clk) disable iff (!rst_b)
		wr_gp_mask |=> gp_mask_q == $past(bus_req.wdata[`DBS_GP_HI_BIT:`DBS_GP_LO_BIT]))
		else $error("port source mask not loaded");

	a_gp_mask_hold: assert property (@(posedge core_clk) disable iff (!rst_b)
		!wr_gp_mask |=> $stable(gp_mask_q))
		else $error("port source mask changed without a write");

	a_gp_mask_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd && bus_req.addr == `DBS_GP_MASK_OFF |=> bus_rdata == {1'b0, $past(gp_mask_q), 28'h0000000})
		else $error("port source mask readback wrong");

	a_status_unused: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd && bus_req.addr == `DBS_STATUS_OFF |=> (bus_rdata & 32'hf3ff_7fff) == 32'h0000_0000)
		else $error("unused status bits not zero");

	a_link_unused: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd && bus_req.addr == `DBS_LINK_OFF |=> (bus_rdata & 32'hffff_fffd) == 32'h0000_0000)
		else $error("unused link status bits not zero");

	// Holes in the map must read as zero so drivers can probe safely
	a_unmapped_read: assert property (@(posedge core_clk) disable iff (!rst_b)
		bus_req.rd && !(bus_req.addr inside {`DBS_RX_BASE_OFF, `DBS_TX_BASE_OFF, `DBS_STATUS_OFF,
			`DBS_IMASK_OFF, `DBS_GP_MASK_OFF, `DBS_LINK_OFF}) |=> bus_rdata == 32'h0000_0000)
		else $error("unmapped read not zero");

endmodule

// *** dv/dbs_host.sv ***
// Host driver model: single-cycle register reads and writes
module dbs_host (
	input  wire logic             core_clk,
	output dbs_pkg::dbs_bus_req_t bus_req,
	input  wire logic [31:0]      bus_rdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial bus_req = '0;
	// Engines stay stopped all run, so base writes are always legal
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		bus_req.addr  <= a;
		bus_req.wdata <= d;
		bus_req.wr    <= 1'b1;
		@(posedge core_clk);
		bus_req.wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe, so sample just past that edge
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge core_clk);
		bus_req.addr <= a;
		bus_req.rd   <= 1'b1;
		@(posedge core_clk);
		bus_req.rd <= 1'b0;
		#1 d = bus_rdata;
	endtask
endmodule

// *** dv/test_descriptor_base_and_status_regs.sv ***
// Self-checking bench for the descriptor base and status register bank
module test_descriptor_base_and_status_regs;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  core_clk, rst_b, link_pass_pin, abn_other, abnormal_summary;
	logic [2:0]            gp_src_event;
	logic [31:0]           bus_rdata, rdv;
	dbs_pkg::dbs_bus_req_t bus_req;
	dbs_pkg::dbs_fetch_t   fetch_base;
	int                    fail_count, comparisons;
	dbs_regs dut_u (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req), .bus_rdata(bus_rdata),
		.link_pass_pin(link_pass_pin), .gp_src_event(gp_src_event), .abn_other(abn_other),
		.fetch_base(fetch_base), .abnormal_summary(abnormal_summary));
	dbs_host host_u (.core_clk(core_clk), .bus_req(bus_req), .bus_rdata(bus_rdata));
	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
		host_u.rd(a, rdv);
		chk(rdv & m, exp);
	endtask
	task automatic pulse_gp(input logic [2:0] e);
		@(posedge core_clk);
		gp_src_event <= e;
		@(posedge core_clk);
		gp_src_event <= 3'h0;
	endtask
	task automatic end_sim;
		if (fail_count == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// Low bits written nonzero on purpose to see them dropped
	task automatic t_bases;
		host_u.wr(8'h18, 32'h1234_5677);
		host_u.wr(8'h20, 32'hfedc_ba9b);
		rdchk(8'h18, 32'hffff_ffff, 32'h1234_5674);
		rdchk(8'h20, 32'hffff_ffff, 32'hfedc_ba98);
		chk(fetch_base.rx_base, 32'h1234_5674);
		chk(fetch_base.tx_base, 32'hfedc_ba98);
		rdchk(8'h70, 32'hffff_ffff, 32'h0000_0000);
	endtask
	task automatic t_gp;
		for (int i = 0; i < 3; i++) begin
			pulse_gp(3'h1 << i);
			rdchk(8'h28, 32'h0c00_0000, 32'h0400_0000);
			rdchk(8'h28, 32'h0c00_0000, 32'h0400_0000);
			chk({31'h0, abnormal_summary}, 32'h1);
			host_u.wr(8'h28, 32'h0000_0000);
			rdchk(8'h28, 32'h0c00_0000, 32'h0400_0000);
			host_u.wr(8'h28, 32'h0400_0000);
			rdchk(8'h28, 32'h0c00_0000, 32'h0000_0000);
		end
		host_u.wr(8'h40, 32'h7000_0000);
		pulse_gp(3'h7);
		rdchk(8'h28, 32'h0c00_0000, 32'h0000_0000);
		host_u.wr(8'h28, 32'h0400_0000);
		host_u.wr(8'h40, 32'h0000_0000);
	endtask
	// Both link directions must flag a change
	task automatic t_link;
		for (int i = 0; i < 2; i++) begin
			host_u.wr(8'h28, 32'h0800_0000);
			rdchk(8'h28, 32'h0c00_0000, 32'h0000_0000);
			@(posedge core_clk);
			link_pass_pin <= ~link_pass_pin;
			repeat (5) @(posedge core_clk);
			rdchk(8'h28, 32'h0c00_0000, 32'h0800_0000);
			rdchk(8'h60, 32'h0000_0002, {30'h0, link_pass_pin, 1'b0});
		end
		@(negedge core_clk);
		chk({31'h0, abnormal_summary}, 32'h1);
		host_u.wr(8'h38, 32'h0800_0000);
		@(negedge core_clk);
		chk({31'h0, abnormal_summary}, 32'h0);
		host_u.wr(8'h28, 32'h0800_0000);
		rdchk(8'h28, 32'h0c00_0000, 32'h0000_0000);
		host_u.wr(8'h38, 32'h0000_0000);
		@(posedge core_clk);
		abn_other <= 1'b1;
		@(negedge core_clk);
		chk({31'h0, abnormal_summary}, 32'h1);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		fail_count = 0;
		comparisons = 0;
		rst_b = 1'b0;
		link_pass_pin = 1'b0;
		abn_other = 1'b0;
		gp_src_event = 3'h0;
		repeat (4) @(posedge core_clk);
		rst_b <= 1'b1;
		t_bases();
		t_gp();
		t_link();
		end_sim();
	end
endmodule
